// >>> fsrm_top.v
`timescale 1ns/1ps
`include "fsrm_map.vh"
module fsrm_top #(
   parameter [19:0] AUTO_DEADLINE_CYC = `FSRM_AUTO_CYC
) (
   input  wire        clk_sys_in,
   input  wire        rst_b_in,
   input  wire        auth_done_in,
   input  wire        blocks_id_in,
   output wire        flash_req_out,
   output wire [1:0]  flash_cmd_out,
   output wire [26:0] flash_addr_out,
   output wire [15:0] flash_wdata_out,
   input  wire [15:0] flash_rdata_in,
   input  wire        flash_ack_in,
   input  wire        host_req_in,
   input  wire        host_we_in,
   input  wire [10:0] host_addr_in,
   input  wire [15:0] host_wdata_in,
   output wire [15:0] host_rdata_out,
   output wire        host_ack_out,
   output wire        host_err_out,
   input  wire        commit_in,
   output wire        busy_out,
   output wire        valid_sector_out,
   output wire        hw_default_out,
   output wire        mirror_ready_out,
   input  wire        ext_req_in,
   input  wire [1:0]  ext_cmd_in,
   input  wire [26:0] ext_addr_in,
   input  wire [15:0] ext_wdata_in,
   output wire [15:0] ext_rdata_out,
   output wire        ext_ack_out,
   output wire        ext_err_out,
   input  wire        swap_req_in,
   output wire        sig_start_out,
   input  wire        sig_done_in,
   input  wire        sig_pass_in,
   output wire        swap_fail_out,
   input  wire        pcie_rst_rel_in,
   input  wire        d3_to_d0_in,
   input  wire        sw_rst_in,
   output wire        cfg_valid_out,
   output wire [10:0] cfg_addr_out,
   output wire [15:0] cfg_data_out,
   output wire        autoload_done_out,
   output wire        autoload_late_out,
   output wire [26:0] phy_base_out,
   output wire        phy_abs_out
);
   // one-hot states
   localparam [11:0] S_WAIT  = 12'h001;
   localparam [11:0] S_CHK   = 12'h002;
   localparam [11:0] S_COPY  = 12'h004;
   localparam [11:0] S_PTR   = 12'h008;
   localparam [11:0] S_IDLE  = 12'h010;
   localparam [11:0] S_HOST  = 12'h020;
   localparam [11:0] S_EXT   = 12'h040;
   localparam [11:0] S_SWAP  = 12'h080;
   localparam [11:0] S_ERASE = 12'h100;
   localparam [11:0] S_PROG  = 12'h200;
   localparam [11:0] S_SIG   = 12'h400;
   localparam [11:0] S_INV   = 12'h800;

   reg  [11:0] st_q;           // main state
   reg         ph_q;           // sub-phase inside a state
   reg  [10:0] idx_q;          // word walker
   reg         fl_req_q;       // flash request held to ack
   reg  [1:0]  fl_cmd_q;
   reg  [26:0] fl_addr_q;
   reg  [15:0] fl_wdata_q;
   reg         s0_ok_q;        // sector 0 signature seen good
   reg         valid_q;        // currently valid sector
   reg         hw_def_q;       // neither sector valid
   reg         ready_q;        // mirror loaded
   reg         tgt_q;          // write-back target sector
   reg         commit_q;       // write-back pending
   reg         swap_q;         // secure swap pending
   reg         sec_sel_q;      // provisioning area is the active secure block
   reg         swap_fail_q;
   reg         sig_start_q;
   reg  [15:0] ptr_sec_q;
   reg  [15:0] ptr_fp_q;
   reg  [15:0] ptr_phy_q;
   reg         host_ack_q;
   reg         host_err_q;
   reg  [15:0] host_rdata_q;
   reg         ext_ack_q;
   reg         ext_err_q;
   reg  [15:0] ext_rdata_q;
   // autoload engine
   reg  [3:0]  evt_q;          // pending por, pcie, d3, sw reset
   reg         auto_act_q;
   reg  [10:0] auto_idx_q;
   reg  [10:0] auto_end_q;
   reg         auto_rd_q;      // read issued last cycle
   reg  [10:0] auto_rd_addr_q;
   reg         cfg_valid_q;
   reg  [10:0] cfg_addr_q;
   reg  [15:0] cfg_data_q;
   reg         auto_done_q;
   reg         auto_late_q;
   reg  [19:0] dl_cnt_q;       // cycles since event taken
   // shadow port
   reg         ram_we;
   reg  [10:0] ram_addr;
   reg  [15:0] ram_wdata;
   wire [15:0] ram_rdata;
   wire [26:0] sec_base;
   wire [26:0] fp_base;
   wire        sec_abs;
   wire        fp_abs;

   // byte address of a word in a config sector
   function [26:0] wrd_addr;
      input       sec;
      input [10:0] w;
      begin
         wrd_addr = {14'h0000, sec, w, 1'b0};
      end
   endfunction

   // shadow words software may not overwrite
   function prot_word;
      input [10:0] a;
      begin
         case (a)
            11'h000, 11'h001, 11'h002, 11'h003, 11'h008, 11'h009, 11'h00a,
            11'h00d, 11'h00e, 11'h010, 11'h011, 11'h012, 11'h017, 11'h022,
            11'h023, 11'h024, 11'h025, 11'h026, 11'h027, 11'h028, 11'h02a,
            11'h02b, 11'h02c, 11'h02d, 11'h02f, 11'h034, 11'h035, 11'h037,
            11'h038, 11'h039, 11'h03a, 11'h03c, 11'h03d, 11'h040, 11'h041,
            11'h044, 11'h045, 11'h046, 11'h047, 11'h048, 11'h04a, 11'h050,
            11'h051: prot_word = 1'b1;
            default: prot_word = 1'b0;
         endcase
      end
   endfunction

   // address inside the config sectors or the active secure block
   function prot_area;
      input [26:0] a;
      input [26:0] base;
      input        abs;
      reg   [27:0] top;
      begin
         top = {1'b0, base} + `FSRM_SEC_BYTES;
         prot_area = (a < `FSRM_CFG_LIMIT) ||
                     (abs && ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top));
      end
   endfunction

   wire [26:0] act_base = sec_sel_q ? fp_base : sec_base;
   wire        act_abs  = sec_sel_q ? fp_abs : sec_abs;
   wire        idle     = (st_q == S_IDLE);
   // arbitration in idle: write-back, swap, external, then host
   wire ext_go  = idle && !commit_q && !swap_q && ext_req_in && !ext_ack_q;
   wire host_go = idle && !commit_q && !swap_q && !ext_go && host_req_in &&
                  !host_ack_q && !auto_act_q;
   wire ext_bad = (ext_cmd_in != `FSRM_CMD_RD) &&
                  prot_area(ext_addr_in, act_base, act_abs);
   wire wb_busy = (st_q == S_ERASE) || (st_q == S_PROG) || (st_q == S_SIG) ||
                  (st_q == S_INV);
   wire fl_done = fl_req_q && flash_ack_in;
   wire sig_ok  = (flash_rdata_in & `FSRM_SIG_MASK) == `FSRM_SIG_OK;

   // shadow port mux; autoload wins so reset loads never wait
   always @* begin
      ram_we    = 1'b0;
      ram_addr  = idx_q;
      ram_wdata = flash_rdata_in;
      if (auto_act_q) begin
         ram_addr = auto_idx_q;
      end else begin
         case (st_q)
            S_COPY: ram_we = fl_done;
            S_PTR: begin
               case (idx_q[1:0])
                  2'h0:    ram_addr = `FSRM_PTR_SEC;
                  2'h1:    ram_addr = `FSRM_PTR_FP;
                  default: ram_addr = `FSRM_PTR_PHY;
               endcase
            end
            S_IDLE: begin
               ram_addr  = host_addr_in;
               ram_wdata = host_wdata_in;
               ram_we    = host_go && host_we_in && !prot_word(host_addr_in);
            end
            default: ram_addr = idx_q;
         endcase
      end
   end

   // main sequencer
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_q <= S_WAIT;         ph_q <= 1'b0;          idx_q <= 11'h000;
         fl_req_q <= 1'b0;       fl_cmd_q <= `FSRM_CMD_RD;
         fl_addr_q <= 27'h0000000; fl_wdata_q <= 16'h0000;
         s0_ok_q <= 1'b0;        valid_q <= 1'b0;       hw_def_q <= 1'b0;
         ready_q <= 1'b0;        tgt_q <= 1'b0;         commit_q <= 1'b0;
         swap_q <= 1'b0;         sec_sel_q <= 1'b0;     swap_fail_q <= 1'b0;
         sig_start_q <= 1'b0;    ptr_sec_q <= 16'h0000; ptr_fp_q <= 16'h0000;
         ptr_phy_q <= 16'h0000;  host_ack_q <= 1'b0;    host_err_q <= 1'b0;
         host_rdata_q <= 16'h0000; ext_ack_q <= 1'b0;   ext_err_q <= 1'b0;
         ext_rdata_q <= 16'h0000;
      end else begin
         host_ack_q  <= 1'b0;
         host_err_q  <= 1'b0;
         ext_ack_q   <= 1'b0;
         ext_err_q   <= 1'b0;
         sig_start_q <= 1'b0;
         // second write-back refused while one runs
         if (commit_in && !wb_busy) commit_q <= 1'b1;
         if (swap_req_in) swap_q <= 1'b1;
         case (st_q)
            // flash untouched until image authenticated and blocks known
            S_WAIT: if (auth_done_in && blocks_id_in) st_q <= S_CHK;
            // read both signature words, prefer the lower sector
            S_CHK: begin
               if (!fl_req_q) begin
                  fl_req_q  <= 1'b1;
                  fl_cmd_q  <= `FSRM_CMD_RD;
                  fl_addr_q <= wrd_addr(idx_q[0], `FSRM_SIG_WORD);
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  if (!idx_q[0]) begin
                     s0_ok_q <= sig_ok;
                     idx_q   <= 11'h001;
                  end else begin
                     idx_q <= 11'h000;
                     if (s0_ok_q || sig_ok) begin
                        valid_q <= !s0_ok_q;
                        st_q    <= S_COPY;
                     end else begin
                        hw_def_q <= 1'b1; // no image: built-in defaults
                        ready_q  <= 1'b1;
                        st_q     <= S_IDLE;
                     end
                  end
               end
            end
            // copy the valid sector word by word into the mirror
            S_COPY: begin
               if (!fl_req_q) begin
                  fl_req_q  <= 1'b1;
                  fl_cmd_q  <= `FSRM_CMD_RD;
                  fl_addr_q <= wrd_addr(valid_q, idx_q);
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  idx_q    <= idx_q + 11'h001;
                  if (idx_q == `FSRM_LAST_WORD) st_q <= S_PTR;
               end
            end
            // fetch secure, provisioning and phy pointers from the mirror
            S_PTR: begin
               if (!ph_q) begin
                  if (!auto_act_q) ph_q <= 1'b1;
               end else begin
                  ph_q <= 1'b0;
                  case (idx_q[1:0])
                     2'h0:    ptr_sec_q <= ram_rdata;
                     2'h1:    ptr_fp_q  <= ram_rdata;
                     default: ptr_phy_q <= ram_rdata;
                  endcase
                  if (idx_q == 11'h002) begin
                     idx_q   <= 11'h000;
                     ready_q <= 1'b1;
                     st_q    <= S_IDLE;
                  end else begin
                     idx_q <= idx_q + 11'h001;
                  end
               end
            end
            S_IDLE: begin
               if (commit_q) begin
                  commit_q <= commit_in; // a pulse on this edge is kept
                  tgt_q    <= hw_def_q ? 1'b0 : !valid_q;
                  idx_q    <= 11'h000;
                  st_q     <= S_ERASE;
               end else if (swap_q) begin
                  swap_q      <= swap_req_in;
                  sig_start_q <= 1'b1;
                  st_q        <= S_SWAP;
               end else if (ext_go) begin
                  if (ext_bad) begin
                     ext_ack_q <= 1'b1;
                     ext_err_q <= 1'b1;
                  end else begin
                     fl_req_q   <= 1'b1;
                     fl_cmd_q   <= ext_cmd_in;
                     fl_addr_q  <= ext_addr_in;
                     fl_wdata_q <= ext_wdata_in;
                     st_q       <= S_EXT;
                  end
               end else if (host_go) begin
                  if (host_we_in && prot_word(host_addr_in)) begin
                     host_ack_q <= 1'b1;
                     host_err_q <= 1'b1;
                  end else begin
                     st_q <= S_HOST;
                  end
               end
            end
            // shadow answers one cycle after the access
            S_HOST: begin
               host_ack_q   <= 1'b1;
               host_rdata_q <= ram_rdata;
               st_q         <= S_IDLE;
            end
            S_EXT: if (fl_done) begin
               fl_req_q    <= 1'b0;
               ext_ack_q   <= 1'b1;
               ext_rdata_q <= flash_rdata_in;
               st_q        <= S_IDLE;
            end
            // signature engine decides whether the new block takes over
            S_SWAP: if (sig_done_in) begin
               if (sig_pass_in) sec_sel_q <= !sec_sel_q;
               swap_fail_q <= !sig_pass_in;
               st_q        <= S_IDLE;
            end
            S_ERASE: begin
               if (!fl_req_q) begin
                  fl_req_q  <= 1'b1;
                  fl_cmd_q  <= `FSRM_CMD_ERASE;
                  fl_addr_q <= wrd_addr(tgt_q, 11'h000);
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  st_q     <= S_PROG;
               end
            end
            // copy mirror out; signature word held back until the end
            S_PROG: begin
               if (!ph_q) begin
                  if (idx_q == `FSRM_SIG_WORD) idx_q <= idx_q + 11'h001;
                  else if (!auto_act_q) ph_q <= 1'b1;
               end else if (!fl_req_q) begin
                  fl_req_q   <= 1'b1;
                  fl_cmd_q   <= `FSRM_CMD_PROG;
                  fl_addr_q  <= wrd_addr(tgt_q, idx_q);
                  fl_wdata_q <= ram_rdata;
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  ph_q     <= 1'b0;
                  idx_q    <= idx_q + 11'h001;
                  if (idx_q == `FSRM_LAST_WORD) st_q <= S_SIG;
               end
            end
            // mark new sector valid only once all data is in
            S_SIG: begin
               if (!fl_req_q) begin
                  fl_req_q   <= 1'b1;
                  fl_cmd_q   <= `FSRM_CMD_PROG;
                  fl_addr_q  <= wrd_addr(tgt_q, `FSRM_SIG_WORD);
                  fl_wdata_q <= `FSRM_SIG_OK;
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  st_q     <= S_INV;
               end
            end
            // retire the old copy; a loss before here leaves it valid
            S_INV: begin
               if (hw_def_q) begin
                  hw_def_q <= 1'b0;
                  valid_q  <= tgt_q;
                  st_q     <= S_IDLE;
               end else if (!fl_req_q) begin
                  fl_req_q   <= 1'b1;
                  fl_cmd_q   <= `FSRM_CMD_PROG;
                  fl_addr_q  <= wrd_addr(!tgt_q, `FSRM_SIG_WORD);
                  fl_wdata_q <= `FSRM_SIG_KILL;
               end else if (flash_ack_in) begin
                  fl_req_q <= 1'b0;
                  valid_q  <= tgt_q;
                  st_q     <= S_IDLE;
               end
            end
            default: st_q <= S_WAIT;
         endcase
      end
   end

   // autoload: streams a section of the mirror after each reset event
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         evt_q <= 4'h1;          auto_act_q <= 1'b0;    auto_idx_q <= 11'h000;
         auto_end_q <= 11'h000;  auto_rd_q <= 1'b0;     auto_rd_addr_q <= 11'h000;
         cfg_valid_q <= 1'b0;    cfg_addr_q <= 11'h000; cfg_data_q <= 16'h0000;
         auto_done_q <= 1'b0;    auto_late_q <= 1'b0;   dl_cnt_q <= 20'h00000;
      end else begin
         auto_done_q    <= 1'b0;
         auto_rd_q      <= auto_act_q;
         auto_rd_addr_q <= auto_idx_q;
         cfg_valid_q    <= auto_rd_q;
         if (auto_rd_q) begin
            cfg_addr_q <= auto_rd_addr_q;
            cfg_data_q <= ram_rdata;
         end
         // new events are kept even as an older one is taken
         if (!auto_act_q && ready_q && (evt_q != 4'h0)) begin
            auto_act_q <= 1'b1;
            auto_idx_q <= 11'h000;
            dl_cnt_q   <= 20'h00000;
            if (evt_q[0]) begin
               auto_end_q <= `FSRM_END_POR;
               evt_q <= {evt_q[3:1] | {sw_rst_in, d3_to_d0_in, pcie_rst_rel_in}, 1'b0};
            end else if (evt_q[1]) begin
               auto_end_q <= `FSRM_END_PCIE;
               evt_q <= {evt_q[3:2] | {sw_rst_in, d3_to_d0_in}, pcie_rst_rel_in, 1'b0};
            end else if (evt_q[2]) begin
               auto_end_q <= `FSRM_END_D3;
               evt_q <= {evt_q[3] | sw_rst_in, d3_to_d0_in,
                         evt_q[1:0] | {pcie_rst_rel_in, 1'b0}};
            end else begin
               auto_end_q <= `FSRM_END_SWRST;
               evt_q <= {sw_rst_in, evt_q[2:0] | {d3_to_d0_in, pcie_rst_rel_in, 1'b0}};
            end
         end else begin
            evt_q <= evt_q | {sw_rst_in, d3_to_d0_in, pcie_rst_rel_in, 1'b0};
            if (auto_act_q) begin
               auto_idx_q <= auto_idx_q + 11'h001;
               if (auto_idx_q == auto_end_q) begin
                  auto_act_q  <= 1'b0;
                  auto_done_q <= 1'b1;
               end
            end
         end
         // deadline watch; stream is short, flag is a safety net
         if (auto_act_q && (dl_cnt_q != AUTO_DEADLINE_CYC)) begin
            dl_cnt_q <= dl_cnt_q + 20'h00001;
         end
         if (auto_act_q && (dl_cnt_q == AUTO_DEADLINE_CYC)) auto_late_q <= 1'b1;
      end
   end

   fsrm_shadow_ram u_ram (
      .clk_sys_in (clk_sys_in),
      .we_in      (ram_we),
      .addr_in    (ram_addr),
      .wdata_in   (ram_wdata),
      .rdata_out  (ram_rdata)
   );

   fsrm_ptr_decode u_ptr (
      .sec_ptr_in   (ptr_sec_q),
      .fp_ptr_in    (ptr_fp_q),
      .phy_ptr_in   (ptr_phy_q),
      .sec_base_out (sec_base),
      .fp_base_out  (fp_base),
      .phy_base_out (phy_base_out),
      .sec_abs_out  (sec_abs),
      .fp_abs_out   (fp_abs),
      .phy_abs_out  (phy_abs_out)
   );

   assign flash_req_out     = fl_req_q;
   assign flash_cmd_out     = fl_cmd_q;
   assign flash_addr_out    = fl_addr_q;
   assign flash_wdata_out   = fl_wdata_q;
   assign host_rdata_out    = host_rdata_q;
   assign host_ack_out      = host_ack_q;
   assign host_err_out      = host_err_q;
   assign busy_out          = wb_busy || commit_q;
   assign valid_sector_out  = valid_q;
   assign hw_default_out    = hw_def_q;
   assign mirror_ready_out  = ready_q;
   assign ext_rdata_out     = ext_rdata_q;
   assign ext_ack_out       = ext_ack_q;
   assign ext_err_out       = ext_err_q;
   assign sig_start_out     = sig_start_q;
   assign swap_fail_out     = swap_fail_q;
   assign cfg_valid_out     = cfg_valid_q;
   assign cfg_addr_out      = cfg_addr_q;
   assign cfg_data_out      = cfg_data_q;
   assign autoload_done_out = auto_done_q;
   assign autoload_late_out = auto_late_q;
endmodule

// >>> fsrm_map.vh
`ifndef FSRM_MAP_VH
`define FSRM_MAP_VH
// flash geometry, byte addresses
`define FSRM_FA_W        27
`define FSRM_CFG_LIMIT   27'h0002000
`define FSRM_SEC_BYTES   28'h00fb000
`define FSRM_LAST_WORD   11'h7ff
// sector signature word and its valid pattern
`define FSRM_SIG_WORD    11'h012
`define FSRM_SIG_MASK    16'h00c0
`define FSRM_SIG_OK      16'h0040
`define FSRM_SIG_KILL    16'h0000
// pointer words in the shadow
`define FSRM_PTR_SEC     11'h010
`define FSRM_PTR_FP      11'h040
`define FSRM_PTR_PHY     11'h7f0
`define FSRM_PTR_ABS_BIT 15
// flash commands
`define FSRM_CMD_RD      2'h0
`define FSRM_CMD_PROG    2'h1
`define FSRM_CMD_ERASE   2'h2
// last word loaded per reset event
`define FSRM_END_POR     11'h7ff
`define FSRM_END_PCIE    11'h03f
`define FSRM_END_D3      11'h01f
`define FSRM_END_SWRST   11'h02f
// autoload deadline, 100 ms of 10 MHz cycles
`define FSRM_AUTO_CYC    20'hf4240
`endif

// >>> fsrm_shadow_ram.v
`timescale 1ns/1ps
module fsrm_shadow_ram (
   input  wire        clk_sys_in,
   input  wire        we_in,
   input  wire [10:0] addr_in,
   input  wire [15:0] wdata_in,
   output reg  [15:0] rdata_out
);
   // 2k words mirror one 4 KB sector; no reset so it maps to a memory
   reg [15:0] mem [0:2047];

   // single port, read-first, one cycle read latency
   always @(posedge clk_sys_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
   end
endmodule

// >>> fsrm_ptr_decode.v
`timescale 1ns/1ps
`include "fsrm_map.vh"
module fsrm_ptr_decode (
   input  wire [15:0] sec_ptr_in,
   input  wire [15:0] fp_ptr_in,
   input  wire [15:0] phy_ptr_in,
   output wire [26:0] sec_base_out,
   output wire [26:0] fp_base_out,
   output wire [26:0] phy_base_out,
   output wire        sec_abs_out,
   output wire        fp_abs_out,
   output wire        phy_abs_out
);
   // low fifteen bits in 4 KB units give the byte address
   function [26:0] unit_addr;
      input [15:0] p;
      begin
         unit_addr = {p[14:0], 12'h000};
      end
   endfunction

   // top bit flags an absolute location beyond the shadow
   assign sec_abs_out  = sec_ptr_in[`FSRM_PTR_ABS_BIT];
   assign fp_abs_out   = fp_ptr_in[`FSRM_PTR_ABS_BIT];
   assign phy_abs_out  = phy_ptr_in[`FSRM_PTR_ABS_BIT];
   assign sec_base_out = unit_addr(sec_ptr_in);
   assign fp_base_out  = unit_addr(fp_ptr_in);
   assign phy_base_out = unit_addr(phy_ptr_in);
endmodule

// >>> fsrm_properties.sv
`timescale 1ns/1ps
module fsrm_properties (
   input wire       clk_sys_in,
   input wire       rst_b_in,
   input wire       auth_done_in,
   input wire       blocks_id_in,
   input wire       flash_req_out,
   input wire [1:0] flash_cmd_out,
   input wire       flash_ack_in,
   input wire       host_ack_out,
   input wire       host_err_out,
   input wire       ext_ack_out,
   input wire       ext_err_out,
   input wire       commit_in,
   input wire       busy_out,
   input wire       valid_sector_out,
   input wire       autoload_late_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // op answered; program or erase still open
   sequence op_done; flash_req_out && flash_ack_in; endsequence
   sequence op_wr; flash_req_out && flash_cmd_out != 2'h0 && !flash_ack_in; endsequence
   req_drop_a: assert property (op_done |=> !flash_req_out) else $error("req kept");
   req_hold_a: assert property (flash_req_out && !flash_ack_in |=> flash_req_out)
      else $error("req lost");
   auth_gate_a: assert property (flash_req_out |-> auth_done_in && blocks_id_in)
      else $error("flash early");
   valid_keep_a: assert property (op_wr |=> $stable(valid_sector_out))
      else $error("valid moved");
   busy_set_a: assert property (commit_in && !busy_out |=> busy_out)
      else $error("no busy");
   busy_end_a: assert property ($fell(busy_out) |-> !flash_req_out)
      else $error("busy fell");
   host_err_a: assert property (host_err_out |-> host_ack_out)
      else $error("host err");
   ext_err_a: assert property (ext_err_out |-> ext_ack_out && !$past(flash_req_out))
      else $error("ext err");
   late_load_a: assert property (!autoload_late_out) else $error("late");
endmodule

// >>> fsrm_flash_model.sv
`timescale 1ns/1ps
module fsrm_flash_model #(parameter DLY = 2) (
   input  wire        clk_sys_in,
   input  wire        flash_req_out,
   input  wire [1:0]  flash_cmd_out,
   input  wire [26:0] flash_addr_out,
   input  wire [15:0] flash_wdata_out,
   output logic [15:0] flash_rdata_in,
   output logic        flash_ack_in
);
   logic [15:0] mem [4096]; // both config sectors
   int          w = 0;      // cycles waited
   wire  [11:0] wi = flash_addr_out[12:1];
   initial begin
      flash_ack_in = 0;
      flash_rdata_in = 0;
      foreach (mem[j]) mem[j] = 16'(j); // all module pointers
      mem[18] = 16'h0040; // only sector 0 valid
      mem[2066] = 16'h0000;
   end
   // slow answer; data toggles when idle so stale data never matches
   always @(posedge clk_sys_in) begin
      flash_ack_in <= 0;
      flash_rdata_in <= ~flash_rdata_in;
      w <= flash_req_out ? w + 1 : 0;
      if (flash_req_out && !flash_ack_in && w >= DLY) begin
         flash_ack_in <= 1;
         flash_rdata_in <= flash_addr_out < 27'h2000 ? mem[wi] : ~flash_addr_out[15:0];
         if (flash_cmd_out == 2'h1) mem[wi] <= flash_wdata_out;
         if (flash_cmd_out == 2'h2) for (int j = 0; j < 2048; j++) mem[{wi[11], 11'(j)}] <= '1;
      end
   end
endmodule

// >>> fsrm_top_bench.sv
`timescale 1ns/1ps
module fsrm_top_bench;
   logic clk_sys_in = 0, rst_b_in = 0, auth_done_in = 0, blocks_id_in = 0, commit_in = 0;
   logic host_req_in = 0, host_we_in = 0, ext_req_in = 0, swap_req_in = 0, sig_done_in = 0;
   logic sig_pass_in = 0, pcie_rst_rel_in = 0, d3_to_d0_in = 0, sw_rst_in = 0;
   logic [1:0] ext_cmd_in = 0;
   logic [10:0] host_addr_in = 0;
   logic [15:0] host_wdata_in = 0, ext_wdata_in = 0;
   logic [26:0] ext_addr_in = 0;
   wire flash_req_out, flash_ack_in, host_ack_out, host_err_out, busy_out, valid_sector_out;
   wire hw_default_out, mirror_ready_out, ext_ack_out, ext_err_out, sig_start_out;
   wire swap_fail_out, cfg_valid_out, phy_abs_out, autoload_done_out, autoload_late_out;
   wire [1:0] flash_cmd_out;
   wire [10:0] cfg_addr_out;
   wire [15:0] flash_wdata_out, flash_rdata_in, host_rdata_out, ext_rdata_out, cfg_data_out;
   wire [26:0] flash_addr_out, phy_base_out;
   int bad_count = 0, n_tests = 0, i, n;
   // write flag, word, data or expected read, refused
   logic [28:0] rows [4] = '{{1'b1, 11'h010, 16'h1234, 1'b1}, {1'b1, 11'h100, 16'hbeef, 1'b0},
      {1'b0, 11'h100, 16'hbeef, 1'b0}, {1'b0, 11'h010, 16'h0010, 1'b0}};
   int ends [3] = '{64, 32, 48}; // words per reset event
   always #50 clk_sys_in = ~clk_sys_in;
   fsrm_top #(.AUTO_DEADLINE_CYC(20'd3000)) dut_u (.*);
   fsrm_flash_model m (.*);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d bad %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a bound that runs out ends the run
   task tmo(input logic ok);
      if (ok !== 1'b1) begin
         bad_count++;
         print_verdict;
      end
   endtask
   initial begin
      repeat (6) @(negedge clk_sys_in);
      rst_b_in = 1;
      repeat (20) @(negedge clk_sys_in);
      {auth_done_in, blocks_id_in} = 2'b11;
      for (i = 0; i < 15000 && !mirror_ready_out; i++) @(posedge clk_sys_in) #1;
      tmo(mirror_ready_out);
      n = 0;
      repeat (2200) @(posedge clk_sys_in) #1 n += cfg_valid_out;
      chk(16'(n), 16'd2048);
      chk(hw_default_out, 0);
      chk({phy_abs_out, phy_base_out[26:12]}, 16'h07f0);
      foreach (rows[r]) begin
         @(negedge clk_sys_in) {host_req_in, host_we_in, host_addr_in, host_wdata_in} =
            {1'b1, rows[r][28:1]};
         for (i = 0; i < 20 && !host_ack_out; i++) @(posedge clk_sys_in) #1;
         tmo(host_ack_out);
         chk(host_err_out, rows[r][0]);
         if (!rows[r][28]) chk(host_rdata_out, rows[r][16:1]);
         @(negedge clk_sys_in) host_req_in = 0;
      end
      $display("host done");
      // config-area program refused, then a read served
      for (int k = 0; k < 2; k++) begin
         @(negedge clk_sys_in) {ext_req_in, ext_cmd_in, ext_addr_in} =
            k ? {3'h4, 27'h3000} : {3'h5, 27'h1000};
         for (i = 0; i < 20 && !ext_ack_out; i++) @(posedge clk_sys_in) #1;
         tmo(ext_ack_out);
         chk(ext_err_out, !k);
         if (k) chk(ext_rdata_out, 16'hcfff);
         @(negedge clk_sys_in) ext_req_in = 0;
      end
      commit_in = 1;
      @(negedge clk_sys_in) commit_in = 0;
      for (i = 0; i < 15000 && busy_out; i++) @(posedge clk_sys_in) #1;
      tmo(!busy_out);
      chk(valid_sector_out, 1);
      chk(m.mem[12'h812], 16'h0040);
      chk(m.mem[12'h012], 16'h0000);
      chk(m.mem[12'h900], 16'hbeef);
      $display("commit done");
      for (int k = 0; k < 2; k++) begin // swap: check fails, then passes
         @(negedge clk_sys_in) swap_req_in = 1;
         @(negedge clk_sys_in) swap_req_in = 0;
         for (i = 0; i < 20 && !sig_start_out; i++) @(posedge clk_sys_in) #1;
         tmo(sig_start_out);
         @(negedge clk_sys_in) {sig_done_in, sig_pass_in} = {1'b1, k[0]};
         @(negedge clk_sys_in) sig_done_in = 0;
         chk(swap_fail_out, !k);
      end
      $display("swap done");
      for (int k = 0; k < 3; k++) begin
         @(negedge clk_sys_in) {pcie_rst_rel_in, d3_to_d0_in, sw_rst_in} = 3'(3'b100 >> k);
         @(negedge clk_sys_in) {pcie_rst_rel_in, d3_to_d0_in, sw_rst_in} = 3'b000;
         n = 0;
         repeat (100) @(posedge clk_sys_in) #1 if (cfg_valid_out) begin
            chk(cfg_addr_out, 16'(n));
            chk(cfg_data_out, n == 18 ? 16'h0040 : 16'(n));
            n++;
         end
         chk(16'(n), 16'(ends[k]));
      end
      $display("events done");
      print_verdict;
   end
endmodule
bind fsrm_top fsrm_properties chk_u (.*);
